// ==== rtl/thermal_alarm_defs.vh ====
`ifndef THERMAL_ALARM_DEFS_VH
`define THERMAL_ALARM_DEFS_VH

// Register offsets
`define ADDR_INT_STATUS_2      8'h42
`define ADDR_ALARM_TIMER_STAT  8'h79
`define ADDR_ALARM_TIME_LIMIT  8'h7A
`define ADDR_TACH_PULSES       8'h7B
`define ADDR_FORMAT_CONFIG     8'h7C
`define ADDR_INT_MASK_2        8'h80

// Reset values
`define RST_ALARM_TIME_LIMIT   8'h00
`define RST_TACH_PULSES        8'h55
`define RST_FORMAT_CONFIG      8'h01
`define RST_INT_MASK_2         8'h00
`define RST_ZERO8              8'h00

// Interrupt status / mask layout
`define INT_OVERRUN_BIT        5

// Format and alarm config fields
`define CFG_FORMAT_BIT         0
`define CFG_OFFSET_RANGE_BIT   1
`define CFG_AUX_DIR_BIT        2
`define CFG_AUX_POL_BIT        3
`define CFG_PIN_GROUP_BIT      4
`define CFG_R1_ALARM_BIT       5
`define CFG_LOCAL_ALARM_BIT    6
`define CFG_R2_ALARM_BIT       7

// Tach pulse fields: two bits per fan, fan n at [2n+1:2n]
`define PULSE_FIELD_W          2
`define PULSE_COUNT_W          3
`define NUM_FANS               4

// Alarm suppression codes
`define LIMIT_OFF_OFF64        8'h00
`define LIMIT_OFF_TWOS         8'h80

// Alarm timer
`define CLK_PERIOD_NS          25
`define ALARM_STEP_NS          22760000
`define ALARM_STEP_CYCLES      (`ALARM_STEP_NS / `CLK_PERIOD_NS)
`define COUNT_REPORT_MIN       8'h02
`define COUNT_MAX              8'hFF

`endif

// ==== rtl/alarm_timer.v ====
`timescale 1ns/100ps
`include "thermal_alarm_defs.vh"

module alarm_timer #(
  parameter STEP_CYCLES = `ALARM_STEP_CYCLES,
  parameter DIV_W       = 20
) (
  // Clock and reset
  input  wire       clk_in,
  input  wire       sys_rst_in,
  // Alarm level and control
  input  wire       asserted_in,
  input  wire [7:0] limit_in,
  input  wire       clear_in,
  // Results
  output wire [7:0] status_out,
  output wire       overrun_out
);

  reg  [DIV_W-1:0] div_reg;
  reg  [7:0]       count_reg;
  reg              asserted_flag_reg;
  reg              prev_reg;
  wire             rise;
  wire             tick;
  wire [7:0]       count_inc;

  assign rise      = asserted_in & ~prev_reg;
  assign tick      = asserted_in & (div_reg == STEP_CYCLES[DIV_W-1:0] - 1'b1);
  assign count_inc = (count_reg == `COUNT_MAX) ? count_reg : count_reg + 8'h01;

  // Partial steps are kept across gaps with no status read, so the total is true assertion time
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_reg           <= {DIV_W{1'b0}};
      count_reg         <= `RST_ZERO8;
      asserted_flag_reg <= 1'b0;
      prev_reg          <= 1'b0;
    end else begin
      prev_reg <= asserted_in;
      if (tick)
        div_reg <= {DIV_W{1'b0}};
      else if (asserted_in)
        div_reg <= div_reg + 1'b1;
      else if (clear_in)
        div_reg <= {DIV_W{1'b0}};
      if (tick)
        count_reg <= clear_in ? 8'h01 : count_inc;
      else if (clear_in)
        count_reg <= `RST_ZERO8;
      if (rise)
        asserted_flag_reg <= 1'b1;
      else if (clear_in)
        asserted_flag_reg <= 1'b0;
    end
  end

  // Upper bits stay zero until two steps have passed
  assign status_out = (count_reg >= `COUNT_REPORT_MIN) ? count_reg :
                      {7'h00, asserted_flag_reg};

  assign overrun_out = ((limit_in == `RST_ZERO8) & rise) |
                       (tick & (count_inc > limit_in));

endmodule

// ==== rtl/channel_alarm.v ====
`timescale 1ns/100ps
`include "thermal_alarm_defs.vh"

module channel_alarm (
  // Channel settings
  input  wire       enable_in,
  input  wire       format_in,
  input  wire [7:0] limit_in,
  // Channel state
  input  wire       over_in,
  // Drive request
  output wire       drive_out
);

  wire [7:0] off_code;

  assign off_code  = format_in ? `LIMIT_OFF_TWOS : `LIMIT_OFF_OFF64;
  assign drive_out = enable_in & over_in & (limit_in != off_code);

endmodule

// ==== rtl/thermal_alarm_regs.v ====
// Summary of operation
// - Eight-bit alarm time limit register, one step is 22.76 ms.
// - Alarm time above limit sets overrun flag, bit 5 of status at 0x42.
// - Limit of zero sets overrun at once when the alarm input asserts.
// - Per fan two-bit code selects one to four tach pulses; default two.
// - Fan fields sit at bits 1:0, 3:2, 5:4 and 7:6.
// - Format bit 0 picks twos complement or offset-64 temperature coding.
// - Bit 1 picks half-degree or one-degree steps for offset registers.
// - Bit 2 makes the enabled auxiliary pin an input or an output.
// - Bit 3 makes the auxiliary output active low or active high.
// - Bit 4 gives five shared pins voltage-id or general purpose use.
// - Bit 5 lets first remote channel drive the alarm pin.
// - Bit 6 lets local channel drive the alarm pin.
// - Bit 7 lets second remote channel drive the alarm pin.
// - Channel limit at the off code never drives the alarm pin.
// - With the lock set, the format and alarm config ignores writes.
// - Asserted flag sets on alarm assertion, clears on status read.
// - Upper timer bits read zero until two steps, then count duration.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "thermal_alarm_defs.vh"

module thermal_alarm_regs #(
  parameter STEP_CYCLES = `ALARM_STEP_CYCLES
) (
  // Clock and reset
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // Register port
  input  wire [7:0]  addr_in,
  input  wire [7:0]  wr_data_in,
  input  wire        wr_en_in,
  input  wire        rd_en_in,
  output reg  [7:0]  rd_data_out,
  // Lock from the main configuration
  input  wire        config_lock_in,
  // Thermal alarm pin, active low
  input  wire        thermal_alarm_pin_in,
  output reg         thermal_alarm_pin_out,
  output reg         thermal_alarm_pin_oe_out,
  // Channel limits and over-limit state: 0 remote one, 1 local, 2 remote two
  input  wire [7:0]  remote_one_limit_in,
  input  wire [7:0]  local_limit_in,
  input  wire [7:0]  remote_two_limit_in,
  input  wire [2:0]  over_limit_in,
  // Auxiliary general-purpose pin
  input  wire        aux_pin_enable_in,
  input  wire        aux_pin_data_in,
  input  wire        auxiliary_io_pin_in,
  output reg         auxiliary_io_pin_out,
  output reg         auxiliary_io_pin_oe_out,
  output reg         aux_pin_level_out,
  // Configuration outputs
  output reg  [11:0] fan_pulse_count_out,
  output reg         temperature_format_select_out,
  output reg         offset_range_select_out,
  output reg         voltage_id_pin_group_select_out,
  // Interrupt
  output reg         irq_out
);

  reg  [7:0]  alarm_time_limit_reg;
  reg  [7:0]  tach_pulses_reg;
  reg  [7:0]  format_config_reg;
  reg  [7:0]  int_status_reg;
  reg  [7:0]  int_mask_reg;

  reg  [7:0]  rd_data_next;
  reg  [7:0]  int_status_next;
  reg  [11:0] fan_pulse_count_next;

  wire        wr_limit;
  wire        wr_pulses;
  wire        wr_config;
  wire        wr_status;
  wire        wr_mask;
  wire        rd_timer;
  wire        alarm_asserted;
  wire [7:0]  timer_status;
  wire        overrun_event;
  wire [2:0]  channel_drive;
  wire [7:0]  channel_limit [0:2];
  wire [7:0]  int_event;
  wire        aux_drive_level;

  integer     fan;

  // Address decode
  assign wr_limit  = wr_en_in & (addr_in == `ADDR_ALARM_TIME_LIMIT);
  assign wr_pulses = wr_en_in & (addr_in == `ADDR_TACH_PULSES);
  assign wr_config = wr_en_in & (addr_in == `ADDR_FORMAT_CONFIG) & ~config_lock_in;
  assign wr_status = wr_en_in & (addr_in == `ADDR_INT_STATUS_2);
  assign wr_mask   = wr_en_in & (addr_in == `ADDR_INT_MASK_2);
  assign rd_timer  = rd_en_in & (addr_in == `ADDR_ALARM_TIMER_STAT);

  // Pin is active low; own drive is seen here too, so the timer counts it
  assign alarm_asserted = ~thermal_alarm_pin_in;

  alarm_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_alarm_timer (
    .clk_in      (clk_in),
    .sys_rst_in  (sys_rst_in),
    .asserted_in (alarm_asserted),
    .limit_in    (alarm_time_limit_reg),
    .clear_in    (rd_timer),
    .status_out  (timer_status),
    .overrun_out (overrun_event)
  );

  assign channel_limit[0] = remote_one_limit_in;
  assign channel_limit[1] = local_limit_in;
  assign channel_limit[2] = remote_two_limit_in;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_channel
      channel_alarm u_channel_alarm (
        .enable_in (format_config_reg[`CFG_R1_ALARM_BIT + ch]),
        .format_in (format_config_reg[`CFG_FORMAT_BIT]),
        .limit_in  (channel_limit[ch]),
        .over_in   (over_limit_in[ch]),
        .drive_out (channel_drive[ch])
      );
    end
  endgenerate

  // Interrupt events, one sticky bit each
  assign int_event = overrun_event ? (8'h01 << `INT_OVERRUN_BIT) : `RST_ZERO8;

  // Set wins over a write-one clear in the same cycle
  always @* begin
    int_status_next = int_status_reg;
    if (wr_status)
      int_status_next = int_status_next & ~wr_data_in;
    int_status_next = int_status_next | int_event;
  end

  // Code n means n+1 pulses per measurement
  always @* begin
    fan_pulse_count_next = 12'h000;
    for (fan = 0; fan < `NUM_FANS; fan = fan + 1) begin
      fan_pulse_count_next[fan*`PULSE_COUNT_W +: `PULSE_COUNT_W] =
        {1'b0, tach_pulses_reg[fan*`PULSE_FIELD_W +: `PULSE_FIELD_W]} + 3'h1;
    end
  end

  // Read mux; unmapped reads return zero
  always @* begin
    rd_data_next = `RST_ZERO8;
    if (rd_en_in) begin
      case (addr_in)
        `ADDR_INT_STATUS_2:     rd_data_next = int_status_reg;
        `ADDR_ALARM_TIMER_STAT: rd_data_next = timer_status;
        `ADDR_ALARM_TIME_LIMIT: rd_data_next = alarm_time_limit_reg;
        `ADDR_TACH_PULSES:      rd_data_next = tach_pulses_reg;
        `ADDR_FORMAT_CONFIG:    rd_data_next = format_config_reg;
        `ADDR_INT_MASK_2:       rd_data_next = int_mask_reg;
        default:                rd_data_next = `RST_ZERO8;
      endcase
    end
  end

  // Auxiliary output polarity
  assign aux_drive_level = format_config_reg[`CFG_AUX_POL_BIT] ?
                           aux_pin_data_in : ~aux_pin_data_in;

  // Register file
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      alarm_time_limit_reg <= `RST_ALARM_TIME_LIMIT;
      tach_pulses_reg      <= `RST_TACH_PULSES;
      format_config_reg    <= `RST_FORMAT_CONFIG;
      int_status_reg       <= `RST_ZERO8;
      int_mask_reg         <= `RST_INT_MASK_2;
    end else begin
      if (wr_limit)
        alarm_time_limit_reg <= wr_data_in;
      if (wr_pulses)
        tach_pulses_reg <= wr_data_in;
      if (wr_config)
        format_config_reg <= wr_data_in;
      if (wr_mask)
        int_mask_reg <= wr_data_in;
      int_status_reg <= int_status_next;
    end
  end

  // Registered outputs
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_data_out                     <= `RST_ZERO8;
      thermal_alarm_pin_out           <= 1'b0;
      thermal_alarm_pin_oe_out        <= 1'b0;
      auxiliary_io_pin_out            <= 1'b0;
      auxiliary_io_pin_oe_out         <= 1'b0;
      aux_pin_level_out               <= 1'b0;
      fan_pulse_count_out             <= 12'h000;
      temperature_format_select_out   <= 1'b0;
      offset_range_select_out         <= 1'b0;
      voltage_id_pin_group_select_out <= 1'b0;
      irq_out                         <= 1'b0;
    end else begin
      rd_data_out <= rd_data_next;
      // Open drain: only ever pulls low
      thermal_alarm_pin_out    <= 1'b0;
      thermal_alarm_pin_oe_out <= |channel_drive;
      auxiliary_io_pin_out     <= aux_drive_level;
      auxiliary_io_pin_oe_out  <= aux_pin_enable_in &
                                  format_config_reg[`CFG_AUX_DIR_BIT];
      aux_pin_level_out        <= auxiliary_io_pin_in;
      fan_pulse_count_out      <= fan_pulse_count_next;
      temperature_format_select_out   <= format_config_reg[`CFG_FORMAT_BIT];
      offset_range_select_out         <= format_config_reg[`CFG_OFFSET_RANGE_BIT];
      voltage_id_pin_group_select_out <= format_config_reg[`CFG_PIN_GROUP_BIT];
      // Level interrupt from the next status so it tracks the flag exactly
      irq_out <= |(int_status_next & ~int_mask_reg);
    end
  end

endmodule

// ==== verif/thermal_alarm_assertions.sv ====
`timescale 1ns/100ps
module thermal_alarm_checker (
  // Clock, reset and register port
  input logic        clk_in,
  input logic        sys_rst_in,
  input logic [7:0]  addr_in,
  input logic [7:0]  wr_data_in,
  input logic        wr_en_in,
  input logic        rd_en_in,
  input logic [7:0]  rd_data_out,
  input logic        config_lock_in,
  // Pins and outputs
  input logic        thermal_alarm_pin_in,
  input logic        thermal_alarm_pin_oe_out,
  input logic [2:0]  over_limit_in,
  input logic        aux_pin_enable_in,
  input logic        auxiliary_io_pin_oe_out,
  input logic [11:0] fan_pulse_count_out,
  input logic        temperature_format_select_out,
  input logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  // Codes 1..4 only; zero or five would mean a field decode slip
  function automatic logic fan_ok(logic [11:0] f);
    fan_ok = 1'b1;
    for (int i = 0; i < 4; i++) if (f[3*i +: 3] == 3'd0 || f[3*i +: 3] > 3'd4) fan_ok = 1'b0;
  endfunction

  a_status_bits_only: assert property (
    $past(rd_en_in) && $past(addr_in) == 8'h42 |-> (rd_data_out & 8'hDF) == 8'h00)
    else $error("interrupt status shows unused bits");
  a_alarm_oe_cause: assert property (
    thermal_alarm_pin_oe_out |-> $past(over_limit_in) != 3'h0)
    else $error("alarm pin driven with no channel over limit");
  a_aux_oe_cause: assert property (
    auxiliary_io_pin_oe_out |-> $past(aux_pin_enable_in))
    else $error("aux pin driven while its function is off");
  a_fan_codes_legal: assert property (
    !$past(sys_rst_in) |-> fan_ok(fan_pulse_count_out))
    else $error("fan pulse count out of range");
  a_lock_holds_config: assert property (
    config_lock_in [*3] |=> $stable(temperature_format_select_out))
    else $error("format changed while locked");
  a_limit_readback: assert property (
    wr_en_in && addr_in == 8'h7A ##1 !wr_en_in ##1 rd_en_in && addr_in == 8'h7A
    |=> rd_data_out == $past(wr_data_in, 3))
    else $error("time limit read differs from write");
  a_format_follows: assert property (
    wr_en_in && addr_in == 8'h7C && !config_lock_in ##1 !wr_en_in
    |=> temperature_format_select_out == $past(wr_data_in[0], 2))
    else $error("format output does not follow write");
  a_flag_on_assert: assert property (
    $fell(thermal_alarm_pin_in) ##2 (rd_en_in && addr_in == 8'h79)
    |=> rd_data_out[7:1] != 7'h00 || rd_data_out[0])
    else $error("asserted flag missing after alarm input");

  c_irq_rise: cover property ($rose(irq_out));
  c_alarm_drive: cover property (thermal_alarm_pin_oe_out);
  c_timer_two: cover property ($past(rd_en_in) && $past(addr_in) == 8'h79 && rd_data_out == 8'h02);
endmodule

bind thermal_alarm_regs thermal_alarm_checker chk_i (.clk_in, .sys_rst_in, .addr_in,
  .wr_data_in, .wr_en_in, .rd_en_in, .rd_data_out, .config_lock_in, .thermal_alarm_pin_in,
  .thermal_alarm_pin_oe_out, .over_limit_in, .aux_pin_enable_in, .auxiliary_io_pin_oe_out,
  .fan_pulse_count_out, .temperature_format_select_out, .irq_out);

// ==== verif/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic        clk_in = 1'b0, sys_rst_in = 1'b1, wr_en_in = 1'b0, rd_en_in = 1'b0;
  logic        config_lock_in = 1'b0, pin_in = 1'b1, aux_en = 1'b0, aux_data = 1'b0;
  logic        aux_pin_in = 1'b0;
  logic [7:0]  addr_in = 8'h00, wr_data_in = 8'h00, lim = 8'h50, rd_data_out;
  logic [2:0]  over = 3'h0;
  logic        pin_out, pin_oe, aux_out, aux_oe, aux_lvl, fmt, ofs, grp, irq_out;
  logic [11:0] fan;
  int          err_count = 0, checks = 0, cycles = 0;

  // Short step keeps the timer test to a few dozen cycles
  thermal_alarm_regs #(.STEP_CYCLES(8)) dut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
    .config_lock_in(config_lock_in), .thermal_alarm_pin_in(pin_in),
    .thermal_alarm_pin_out(pin_out), .thermal_alarm_pin_oe_out(pin_oe),
    .remote_one_limit_in(lim), .local_limit_in(lim), .remote_two_limit_in(lim),
    .over_limit_in(over), .aux_pin_enable_in(aux_en), .aux_pin_data_in(aux_data),
    .auxiliary_io_pin_in(aux_pin_in), .auxiliary_io_pin_out(aux_out),
    .auxiliary_io_pin_oe_out(aux_oe), .aux_pin_level_out(aux_lvl),
    .fan_pulse_count_out(fan), .temperature_format_select_out(fmt),
    .offset_range_select_out(ofs), .voltage_id_pin_group_select_out(grp), .irq_out(irq_out));

  initial forever #12.5 clk_in = ~clk_in;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string what, logic [11:0] seen, logic [11:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 chk(what, rd_data_out, exp);
  endtask

  task automatic drv(logic [7:0] cfg, logic [2:0] ov, logic [7:0] l, logic e);
    wr(8'h7C, cfg);
    over <= ov;
    lim <= l;
    wait_n(3);
    chk("alarm drive", {pin_out, pin_oe}, {1'b0, e});
  endtask

  task automatic t_reset();
    rd(8'h7A, 8'h00, "limit reset");
    rd(8'h7B, 8'h55, "pulses reset");
    rd(8'h7C, 8'h01, "config reset");
    rd(8'h42, 8'h00, "status reset");
    rd(8'h7E, 8'h00, "unmapped read");
    chk("fan reset", fan, 12'h492);
    chk("format reset", {fmt, ofs, grp}, 3'b100);
    $display("reset test done");
  endtask

  task automatic t_fans();
    wr(8'h7B, 8'h1B);
    wait_n(2);
    chk("fan counts a", fan, 12'h29C);
    wr(8'h7B, 8'hE4);
    wait_n(2);
    chk("fan counts b", fan, 12'h8D1);
    rd(8'h7B, 8'hE4, "pulses readback");
    $display("fan test done");
  endtask

  task automatic t_config();
    wr(8'h7C, 8'hFE);
    wait_n(2);
    chk("format bits", {fmt, ofs, grp}, 3'b011);
    @(posedge clk_in);
    config_lock_in <= 1'b1;
    wr(8'h7C, 8'h01);
    rd(8'h7C, 8'hFE, "locked config");
    @(posedge clk_in);
    config_lock_in <= 1'b0;
    aux_en <= 1'b1;
    aux_data <= 1'b1;
    aux_pin_in <= 1'b1;
    wait_n(2);
    chk("aux high", {aux_oe, aux_out, aux_lvl}, 3'b111);
    wr(8'h7C, 8'hF6);
    wait_n(2);
    chk("aux low", {aux_oe, aux_out}, 2'b10);
    wr(8'h7C, 8'hFA);
    wait_n(2);
    chk("aux input", aux_oe, 1'b0);
    $display("config test done");
  endtask

  task automatic t_drive();
    drv(8'h20, 3'b001, 8'h50, 1'b1);
    drv(8'h20, 3'b110, 8'h50, 1'b0);
    drv(8'h40, 3'b010, 8'h50, 1'b1);
    drv(8'h80, 3'b100, 8'h50, 1'b1);
    drv(8'hE0, 3'b111, 8'h00, 1'b0);
    drv(8'hE1, 3'b111, 8'h00, 1'b1);
    drv(8'hE1, 3'b111, 8'h80, 1'b0);
    $display("drive test done");
  endtask

  task automatic t_timer();
    wr(8'h7A, 8'h01);
    rd(8'h7A, 8'h01, "limit readback");
    @(posedge clk_in);
    pin_in <= 1'b0;
    wait_n(1);
    rd(8'h79, 8'h01, "asserted flag");
    rd(8'h79, 8'h00, "flag cleared");
    // Reads land between the second and third step
    wait_n(16);
    rd(8'h79, 8'h02, "two steps");
    chk("overrun irq", irq_out, 1'b1);
    rd(8'h42, 8'h20, "overrun flag");
    @(posedge clk_in);
    pin_in <= 1'b1;
    wr(8'h42, 8'h20);
    wait_n(1);
    chk("irq cleared", irq_out, 1'b0);
    wr(8'h80, 8'h20);
    wr(8'h7A, 8'h00);
    pin_in <= 1'b0;
    wait_n(3);
    chk("masked irq", irq_out, 1'b0);
    rd(8'h42, 8'h20, "zero limit overrun");
    wr(8'h80, 8'h00);
    wait_n(2);
    chk("unmasked irq", irq_out, 1'b1);
    $display("timer test done");
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_fans();
    t_config();
    t_drive();
    t_timer();
    end_of_test();
  end
endmodule
